// >>> core/exec_pkg.sv
// exec_pkg: types and constants of the branch, skip and bit unit
// assumes one core clock; the status flags and I/O registers live outside
package exec_pkg;

    localparam int unsigned PC_W      = 16;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned IO_ADDR_W = 6;

    // positions in the status flags register
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    typedef logic [2:0] cycles_t;

    // cycle counts per instruction
    localparam cycles_t CYC_ONE          = 3'h1;
    localparam cycles_t CYC_POINTER_JUMP = 3'h2;
    localparam cycles_t CYC_POINTER_CALL = 3'h3;
    localparam cycles_t CYC_RETURN       = 3'h4;
    localparam cycles_t CYC_BRANCH_TAKEN = 3'h2;
    localparam cycles_t CYC_SKIP_ONE     = 3'h2;
    localparam cycles_t CYC_SKIP_TWO     = 3'h3;
    localparam cycles_t CYC_IO_BIT       = 3'h2;

    // program counter steps
    localparam logic [PC_W-1:0] PC_STEP     = 16'h0001;
    localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;

    // reset values
    localparam logic [PC_W-1:0]   PC_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;

    typedef enum logic [4:0] {
        NO_OP, POINTER_JUMP, POINTER_CALL, SUB_RETURN, INTERRUPT_RETURN,
        COMPARE_SKIP_EQUAL, COMPARE, COMPARE_WITH_CARRY, COMPARE_IMMEDIATE,
        SKIP_REG_BIT_CLEAR, SKIP_REG_BIT_SET, SKIP_IO_BIT_CLEAR,
        SKIP_IO_BIT_SET, BRANCH_FLAG_SET, BRANCH_FLAG_CLEAR,
        BRANCH_UNSIGNED_GE, BRANCH_UNSIGNED_LT, BRANCH_SIGNED_GE,
        BRANCH_SIGNED_LT, BRANCH_HALFCARRY_SET, BRANCH_HALFCARRY_CLEAR,
        BRANCH_COPYBIT_SET, BRANCH_COPYBIT_CLEAR, BRANCH_OVERFLOW_SET,
        BRANCH_OVERFLOW_CLEAR, BRANCH_IRQ_ENABLED, BRANCH_IRQ_DISABLED,
        IO_BIT_SET, IO_BIT_CLEAR, SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL
    } op_kind_t;

    typedef enum logic [1:0] {
        SUBTRACT, SUBTRACT_CARRY, SHIFT_LEFT, SHIFT_RIGHT
    } alu_mode_t;

    // one decoded instruction with its operand values
    typedef struct packed {
        op_kind_t              kind;
        logic [DATA_W-1:0]     rd_val;
        logic [DATA_W-1:0]     rr_val;
        logic [DATA_W-1:0]     imm;
        logic [2:0]            bit_sel;
        logic [6:0]            offset;
        logic [IO_ADDR_W-1:0]  io_addr;
        logic [DATA_W-1:0]     io_val;
        logic                  skip_two_word;
    } op_t;

    // everything an instruction commits when it completes
    typedef struct packed {
        logic                  done;
        logic                  pc_load;
        logic [PC_W-1:0]       pc_next;
        logic                  flags_we;
        logic [DATA_W-1:0]     flags;
        logic                  reg_we;
        logic [DATA_W-1:0]     reg_wdata;
        logic                  io_we;
        logic [IO_ADDR_W-1:0]  io_addr;
        logic [DATA_W-1:0]     io_wdata;
        logic                  push_we;
        logic [PC_W-1:0]       push_addr;
    } result_t;

endpackage : exec_pkg

// >>> core/sub_shift_alu.sv
// sub_shift_alu: subtract and logical shift with flag results
// assumes operands and flags settle within the same core clock cycle
`timescale 1ns/10ps
`default_nettype none

module sub_shift_alu (
    input  wire exec_pkg::alu_mode_t          mode,
    input  wire logic [exec_pkg::DATA_W-1:0]  a,
    input  wire logic [exec_pkg::DATA_W-1:0]  b,
    input  wire logic [exec_pkg::DATA_W-1:0]  flags_in,
    output logic      [exec_pkg::DATA_W-1:0]  result,
    output logic      [exec_pkg::DATA_W-1:0]  flags_out
);

    logic [exec_pkg::DATA_W-1:0] r;
    logic                        cin;

    // flags written back only for the bits each mode owns
    always_comb
    begin
        flags_out = flags_in;
        cin       = (mode == exec_pkg::SUBTRACT_CARRY)
                    & flags_in[exec_pkg::FLAG_C];
        r         = 8'(a - b - {7'h00, cin});
        unique case (mode)
            exec_pkg::SUBTRACT, exec_pkg::SUBTRACT_CARRY:
            begin
                flags_out[exec_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3])
                                              | (r[3] & ~a[3]);
                flags_out[exec_pkg::FLAG_V] = (a[7] & ~b[7] & ~r[7])
                                              | (~a[7] & b[7] & r[7]);
                flags_out[exec_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7])
                                              | (r[7] & ~a[7]);
            end
            exec_pkg::SHIFT_LEFT:
            begin
                r = {a[6:0], 1'b0};
                flags_out[exec_pkg::FLAG_C] = a[7];
                flags_out[exec_pkg::FLAG_V] = r[7] ^ a[7];
            end
            exec_pkg::SHIFT_RIGHT:
            begin
                r = {1'b0, a[7:1]};
                flags_out[exec_pkg::FLAG_C] = a[0];
                flags_out[exec_pkg::FLAG_V] = a[0];
            end
        endcase
        flags_out[exec_pkg::FLAG_N] = r[7];
        // a carried compare keeps zero only if the lower byte was zero too
        flags_out[exec_pkg::FLAG_Z] = (r == 8'h00)
            & ((mode != exec_pkg::SUBTRACT_CARRY) | flags_in[exec_pkg::FLAG_Z]);
        flags_out[exec_pkg::FLAG_S] = flags_out[exec_pkg::FLAG_N]
                                      ^ flags_out[exec_pkg::FLAG_V];
        result = r;
    end

endmodule : sub_shift_alu
`default_nettype wire

// >>> core/branch_skip_bit_exec_unit.sv
// branch_skip_bit_exec_unit: executes control flow and bit test
// instructions and times each one to its documented cycle count
// assumes the decoder presents operand values with the instruction and
// that the caller commits the result strobes on the cycle they show
`timescale 1ns/10ps
`default_nettype none

module branch_skip_bit_exec_unit (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             in_valid,
    input  wire exec_pkg::op_t                    in_op,
    input  wire logic [exec_pkg::PC_W-1:0]        pc_in,
    input  wire logic [exec_pkg::PC_W-1:0]        z_in,
    input  wire logic [exec_pkg::PC_W-1:0]        stack_in,
    input  wire logic [exec_pkg::DATA_W-1:0]      flags_in,
    output logic                                  in_ready,
    output exec_pkg::result_t                     res
);

    typedef enum logic {
        IDLE,
        BUSY
    } phase_t;

    typedef struct packed {
        phase_t               phase;
        exec_pkg::cycles_t    cnt;
        logic                 ready;
        exec_pkg::result_t    pend;
        exec_pkg::result_t    res;
    } state_t;

    state_t                          st_q;
    state_t                          st_d;
    exec_pkg::result_t               dec_res;
    exec_pkg::cycles_t               dec_cyc;
    exec_pkg::alu_mode_t             alu_mode;
    logic [exec_pkg::DATA_W-1:0]     alu_b;
    logic [exec_pkg::DATA_W-1:0]     alu_result;
    logic [exec_pkg::DATA_W-1:0]     alu_flags;
    logic [exec_pkg::DATA_W-1:0]     cur_flags;
    logic [exec_pkg::PC_W-1:0]       pc_plus1;
    logic [exec_pkg::PC_W-1:0]       pc_rel;
    logic [exec_pkg::PC_W-1:0]       pc_skip;
    exec_pkg::cycles_t               skip_cyc;
    logic                            is_skip;
    logic                            skip_hit;
    logic                            is_branch;
    logic                            branch_hit;
    logic                            take;

    // single bit pick, shared by register, I/O and flag tests
    function automatic logic bit_of(
        input logic [exec_pkg::DATA_W-1:0] v,
        input logic [2:0]                  sel
    );
        bit_of = v[sel];
    endfunction : bit_of

    // one-hot mask for the I/O bit write
    function automatic logic [exec_pkg::DATA_W-1:0] bit_mask(
        input logic [2:0] sel
    );
        bit_mask = 8'(8'h01 << sel);
    endfunction : bit_mask

    assign take = in_valid & st_q.ready;

    // flags committed last cycle are not yet back on flags_in, so a
    // compare followed at once by a branch must see them forwarded
    assign cur_flags = (st_q.res.done & st_q.res.flags_we)
                       ? st_q.res.flags : flags_in;

    // program counter targets
    assign pc_plus1 = 16'(pc_in + exec_pkg::PC_STEP);
    assign pc_rel   = 16'(pc_in + {{9{in_op.offset[6]}}, in_op.offset}
                          + exec_pkg::PC_STEP);
    assign pc_skip  = in_op.skip_two_word
                      ? 16'(pc_in + exec_pkg::PC_SKIP_TWO)
                      : 16'(pc_in + exec_pkg::PC_SKIP_ONE);
    assign skip_cyc = in_op.skip_two_word
                      ? exec_pkg::CYC_SKIP_TWO : exec_pkg::CYC_SKIP_ONE;

    // alu operand and mode selection
    always_comb
    begin
        alu_b    = in_op.rr_val;
        alu_mode = exec_pkg::SUBTRACT;
        unique case (in_op.kind)
            exec_pkg::COMPARE_IMMEDIATE:
                alu_b = in_op.imm;
            exec_pkg::COMPARE_WITH_CARRY:
                alu_mode = exec_pkg::SUBTRACT_CARRY;
            exec_pkg::SHIFT_LEFT_LOGICAL:
                alu_mode = exec_pkg::SHIFT_LEFT;
            exec_pkg::SHIFT_RIGHT_LOGICAL:
                alu_mode = exec_pkg::SHIFT_RIGHT;
            default:
                alu_mode = exec_pkg::SUBTRACT;
        endcase
    end

    sub_shift_alu alu_i (
        .mode      (alu_mode),
        .a         (in_op.rd_val),
        .b         (alu_b),
        .flags_in  (cur_flags),
        .result    (alu_result),
        .flags_out (alu_flags)
    );

    // decode: what the instruction commits and how long it takes
    always_comb
    begin
        dec_res         = '0;
        dec_res.done    = 1'b1;
        dec_res.pc_load = 1'b1;
        dec_res.pc_next = pc_plus1;
        dec_res.flags   = cur_flags;
        dec_res.io_addr = in_op.io_addr;
        dec_cyc         = exec_pkg::CYC_ONE;
        is_skip         = 1'b0;
        skip_hit        = 1'b0;
        is_branch       = 1'b0;
        branch_hit      = 1'b0;
        unique case (in_op.kind)
            exec_pkg::NO_OP:
                dec_cyc = exec_pkg::CYC_ONE;
            exec_pkg::POINTER_JUMP:
            begin
                dec_res.pc_next = z_in;
                dec_cyc         = exec_pkg::CYC_POINTER_JUMP;
            end
            exec_pkg::POINTER_CALL:
            begin
                dec_res.pc_next   = z_in;
                dec_res.push_we   = 1'b1;
                dec_res.push_addr = pc_plus1;
                dec_cyc           = exec_pkg::CYC_POINTER_CALL;
            end
            exec_pkg::SUB_RETURN:
            begin
                dec_res.pc_next = stack_in;
                dec_cyc         = exec_pkg::CYC_RETURN;
            end
            exec_pkg::INTERRUPT_RETURN:
            begin
                dec_res.pc_next                 = stack_in;
                dec_res.flags_we                = 1'b1;
                dec_res.flags[exec_pkg::FLAG_I] = 1'b1;
                dec_cyc                         = exec_pkg::CYC_RETURN;
            end
            exec_pkg::COMPARE_SKIP_EQUAL:
            begin
                is_skip  = 1'b1;
                skip_hit = (in_op.rd_val == in_op.rr_val);
            end
            exec_pkg::COMPARE, exec_pkg::COMPARE_WITH_CARRY,
            exec_pkg::COMPARE_IMMEDIATE:
            begin
                dec_res.flags_we = 1'b1;
                dec_res.flags    = alu_flags;
            end
            exec_pkg::SKIP_REG_BIT_CLEAR:
            begin
                is_skip  = 1'b1;
                skip_hit = ~bit_of(in_op.rr_val, in_op.bit_sel);
            end
            exec_pkg::SKIP_REG_BIT_SET:
            begin
                is_skip  = 1'b1;
                skip_hit = bit_of(in_op.rr_val, in_op.bit_sel);
            end
            exec_pkg::SKIP_IO_BIT_CLEAR:
            begin
                is_skip  = 1'b1;
                skip_hit = ~bit_of(in_op.io_val, in_op.bit_sel);
            end
            exec_pkg::SKIP_IO_BIT_SET:
            begin
                is_skip  = 1'b1;
                skip_hit = bit_of(in_op.io_val, in_op.bit_sel);
            end
            exec_pkg::BRANCH_FLAG_SET:
            begin
                is_branch  = 1'b1;
                branch_hit = bit_of(cur_flags, in_op.bit_sel);
            end
            exec_pkg::BRANCH_FLAG_CLEAR:
            begin
                is_branch  = 1'b1;
                branch_hit = ~bit_of(cur_flags, in_op.bit_sel);
            end
            // same or higher on no carry
            exec_pkg::BRANCH_UNSIGNED_GE:
            begin
                is_branch  = 1'b1;
                branch_hit = ~cur_flags[exec_pkg::FLAG_C];
            end
            exec_pkg::BRANCH_UNSIGNED_LT:
            begin
                is_branch  = 1'b1;
                branch_hit = cur_flags[exec_pkg::FLAG_C];
            end
            exec_pkg::BRANCH_SIGNED_GE:
            begin
                is_branch  = 1'b1;
                branch_hit = ~(cur_flags[exec_pkg::FLAG_N]
                               ^ cur_flags[exec_pkg::FLAG_V]);
            end
            exec_pkg::BRANCH_SIGNED_LT:
            begin
                is_branch  = 1'b1;
                branch_hit = cur_flags[exec_pkg::FLAG_N]
                             ^ cur_flags[exec_pkg::FLAG_V];
            end
            exec_pkg::BRANCH_HALFCARRY_SET:
            begin
                is_branch  = 1'b1;
                branch_hit = cur_flags[exec_pkg::FLAG_H];
            end
            exec_pkg::BRANCH_HALFCARRY_CLEAR:
            begin
                is_branch  = 1'b1;
                branch_hit = ~cur_flags[exec_pkg::FLAG_H];
            end
            exec_pkg::BRANCH_COPYBIT_SET:
            begin
                is_branch  = 1'b1;
                branch_hit = cur_flags[exec_pkg::FLAG_T];
            end
            exec_pkg::BRANCH_COPYBIT_CLEAR:
            begin
                is_branch  = 1'b1;
                branch_hit = ~cur_flags[exec_pkg::FLAG_T];
            end
            exec_pkg::BRANCH_OVERFLOW_SET:
            begin
                is_branch  = 1'b1;
                branch_hit = cur_flags[exec_pkg::FLAG_V];
            end
            exec_pkg::BRANCH_OVERFLOW_CLEAR:
            begin
                is_branch  = 1'b1;
                branch_hit = ~cur_flags[exec_pkg::FLAG_V];
            end
            exec_pkg::BRANCH_IRQ_ENABLED:
            begin
                is_branch  = 1'b1;
                branch_hit = cur_flags[exec_pkg::FLAG_I];
            end
            exec_pkg::BRANCH_IRQ_DISABLED:
            begin
                is_branch  = 1'b1;
                branch_hit = ~cur_flags[exec_pkg::FLAG_I];
            end
            exec_pkg::IO_BIT_SET:
            begin
                dec_res.io_we    = 1'b1;
                dec_res.io_wdata = in_op.io_val | bit_mask(in_op.bit_sel);
                dec_cyc          = exec_pkg::CYC_IO_BIT;
            end
            exec_pkg::IO_BIT_CLEAR:
            begin
                dec_res.io_we    = 1'b1;
                dec_res.io_wdata = in_op.io_val & ~bit_mask(in_op.bit_sel);
                dec_cyc          = exec_pkg::CYC_IO_BIT;
            end
            exec_pkg::SHIFT_LEFT_LOGICAL, exec_pkg::SHIFT_RIGHT_LOGICAL:
            begin
                dec_res.reg_we    = 1'b1;
                dec_res.reg_wdata = alu_result;
                dec_res.flags_we  = 1'b1;
                dec_res.flags     = alu_flags;
            end
        endcase
        if (is_skip & skip_hit)
        begin
            dec_res.pc_next = pc_skip;
            dec_cyc         = skip_cyc;
        end
        if (is_branch & branch_hit)
        begin
            dec_res.pc_next = pc_rel;
            dec_cyc         = exec_pkg::CYC_BRANCH_TAKEN;
        end
    end

    // sequencer: one-cycle ops commit at once, longer ones count down
    always_comb
    begin
        st_d              = st_q;
        // commit strobes are single-cycle pulses
        st_d.res.done     = 1'b0;
        st_d.res.pc_load  = 1'b0;
        st_d.res.flags_we = 1'b0;
        st_d.res.reg_we   = 1'b0;
        st_d.res.io_we    = 1'b0;
        st_d.res.push_we  = 1'b0;
        unique case (st_q.phase)
            IDLE:
            begin
                if (take)
                begin
                    if (dec_cyc == exec_pkg::CYC_ONE)
                    begin
                        st_d.res = dec_res;
                    end
                    else
                    begin
                        // operands are captured now, so the decoder may
                        // move on while the unit is busy
                        st_d.pend  = dec_res;
                        st_d.cnt   = 3'(dec_cyc - exec_pkg::CYC_ONE);
                        st_d.phase = BUSY;
                        st_d.ready = 1'b0;
                    end
                end
            end
            BUSY:
            begin
                if (st_q.cnt == exec_pkg::CYC_ONE)
                begin
                    st_d.res   = st_q.pend;
                    st_d.phase = IDLE;
                    st_d.ready = 1'b1;
                end
                else
                begin
                    st_d.cnt = 3'(st_q.cnt - exec_pkg::CYC_ONE);
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q               <= '0;
            st_q.phase         <= IDLE;
            st_q.ready         <= 1'b1;
            st_q.res.pc_next   <= exec_pkg::PC_RESET;
            st_q.res.flags     <= exec_pkg::FLAGS_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign in_ready = st_q.ready;
    assign res      = st_q.res;

endmodule : branch_skip_bit_exec_unit
`default_nettype wire

// >>> testbench/branch_skip_bit_exec_unit_chk.sv
// checker for branch_skip_bit_exec_unit: cycle counts and results
// assumes a bind to the unit's ports, one clock, async high reset
`timescale 1ns/10ps
`default_nettype none

module branch_skip_bit_exec_unit_chk (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        in_valid,
    input  wire exec_pkg::op_t               in_op,
    input  wire logic [exec_pkg::PC_W-1:0]   pc_in,
    input  wire logic [exec_pkg::PC_W-1:0]   z_in,
    input  wire logic [exec_pkg::PC_W-1:0]   stack_in,
    input  wire logic [exec_pkg::DATA_W-1:0] flags_in,
    input  wire logic                        in_ready,
    input  wire exec_pkg::result_t           res
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // take only on an idle edge; target kept for taken branches
    logic        take;
    logic [15:0] tgt;
    assign take = in_valid && in_ready;
    assign tgt  = pc_in + {{9{in_op.offset[6]}}, in_op.offset} + 16'h0001;
    sequence s_busy;
        !res.done && !in_ready;
    endsequence
    sequence s_one;
        res.done && !res.flags_we && res.pc_next == $past(pc_in) + 16'h0001;
    endsequence
    property p_jump;
        take && in_op.kind == exec_pkg::POINTER_JUMP |=> s_busy ##1
        res.done && !res.flags_we && res.pc_next == $past(z_in, 2);
    endproperty
    property p_call;
        take && in_op.kind == exec_pkg::POINTER_CALL |=> s_busy [*2] ##1
        res.done && res.push_we && res.pc_next == $past(z_in, 3) &&
        res.push_addr == $past(pc_in, 3) + 16'h0001 && !res.flags_we;
    endproperty
    property p_interrupt_return;
        take && in_op.kind == exec_pkg::INTERRUPT_RETURN |=> s_busy [*3]
        ##1 res.done && res.flags_we && res.flags[exec_pkg::FLAG_I] &&
        res.pc_next == $past(stack_in, 4);
    endproperty
    property p_cmp;
        take && in_op.kind == exec_pkg::COMPARE |=> res.done &&
        res.flags_we && res.pc_next == $past(pc_in) + 16'h0001 &&
        res.flags[exec_pkg::FLAG_Z] == ($past(in_op.rd_val) ==
        $past(in_op.rr_val));
    endproperty
    property p_cse;
        take && in_op.kind == exec_pkg::COMPARE_SKIP_EQUAL &&
        in_op.rd_val == in_op.rr_val && !in_op.skip_two_word |=> s_busy
        ##1 res.done && !res.flags_we &&
        res.pc_next == $past(pc_in, 2) + 16'h0002;
    endproperty
    property p_sbi;
        take && in_op.kind == exec_pkg::IO_BIT_SET |=> s_busy ##1 res.done
        && res.io_we && res.io_wdata == ($past(in_op.io_val, 2) |
        (8'h01 << $past(in_op.bit_sel, 2)));
    endproperty
    property p_cbi;
        take && in_op.kind == exec_pkg::IO_BIT_CLEAR |=> s_busy ##1
        res.done && res.io_we && res.io_wdata == ($past(in_op.io_val, 2)
        & ~(8'h01 << $past(in_op.bit_sel, 2)));
    endproperty
    // untaken in one cycle, taken in two, never touching flags
    property p_br;
        take && in_op.kind inside {[exec_pkg::BRANCH_FLAG_SET:
        exec_pkg::BRANCH_IRQ_DISABLED]} |=> s_one or (s_busy ##1 res.done
        && !res.flags_we && res.pc_next == $past(tgt, 2));
    endproperty
    a_jump: assert property (p_jump) else $error("jump wrong");
    a_call: assert property (p_call) else $error("call wrong");
    a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt_return wrong");
    a_cmp: assert property (p_cmp) else $error("compare wrong");
    a_cse: assert property (p_cse) else $error("skip wrong");
    a_sbi: assert property (p_sbi) else $error("bit set wrong");
    a_cbi: assert property (p_cbi) else $error("bit clr wrong");
    a_br: assert property (p_br) else $error("branch wrong");
endmodule : branch_skip_bit_exec_unit_chk

`default_nettype wire

// >>> testbench/branch_skip_bit_exec_unit_tb.sv
// bench for branch_skip_bit_exec_unit: directed instruction tests
// assumes the package, the unit and its checker are compiled first
`timescale 1ns/10ps
`default_nettype none

module branch_skip_bit_exec_unit_tb;
    logic              clk      = 1'b0;
    logic              rst      = 1'b1;
    logic              in_valid = 1'b0;
    exec_pkg::op_t     in_op    = '0;
    logic [15:0]       pc_in    = 16'h0200;
    logic [15:0]       z_in     = 16'h1234;
    logic [15:0]       stack_in = 16'h0abc;
    logic [7:0]        flags_in = 8'h00;
    logic              in_ready;
    exec_pkg::result_t res;
    int                err_count = 0;
    int                n_tests   = 0;

    branch_skip_bit_exec_unit dut_u (.clk(clk), .rst(rst),
        .in_valid(in_valid), .in_op(in_op), .pc_in(pc_in), .z_in(z_in),
        .stack_in(stack_in), .flags_in(flags_in), .in_ready(in_ready),
        .res(res));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic check(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check

    function automatic exec_pkg::op_t mk(exec_pkg::op_kind_t k,
        logic [7:0] a, logic [7:0] b, logic [2:0] s, logic tw);
        mk = '0;
        mk.kind = k;
        mk.rd_val = a;
        mk.rr_val = b;
        mk.imm = b;
        mk.bit_sel = s;
        mk.offset = 7'h7c; // minus four
        mk.io_addr = 6'h15;
        mk.io_val = a;
        mk.skip_two_word = tw;
    endfunction : mk

    // offer held until idle, then counts cycles to done
    task automatic run(input exec_pkg::op_t op, input int n,
        input logic [15:0] epc);
        int c;
        c = 1;
        @(negedge clk);
        in_op = op;
        in_valid = 1'b1;
        while (in_ready !== 1'b1)
        begin
            @(negedge clk);
        end
        @(negedge clk);
        in_valid = 1'b0;
        while (res.done !== 1'b1 && c < 8)
        begin
            @(negedge clk);
            c++;
        end
        check(c == n && res.pc_load && res.pc_next === epc, "cycles or pc");
    endtask : run

    task automatic sk(exec_pkg::op_kind_t k, logic [7:0] a, logic [7:0] b,
        logic tw, int n);
        run(mk(k, a, b, 3'h3, tw), n, 16'h0200 + 16'(n));
    endtask : sk

    task automatic t_flow();
        run(mk(exec_pkg::POINTER_JUMP, 0, 0, 0, 0), 2, 16'h1234);
        run(mk(exec_pkg::POINTER_CALL, 0, 0, 0, 0), 3, 16'h1234);
        check(res.push_we && res.push_addr === 16'h0201, "push");
        run(mk(exec_pkg::SUB_RETURN, 0, 0, 0, 0), 4, 16'h0abc);
        check(res.flags_we === 1'b0, "ret flags");
        run(mk(exec_pkg::INTERRUPT_RETURN, 0, 0, 0, 0), 4, 16'h0abc);
        check(res.flags[7] === 1'b1, "interrupt_return enable");
        $display("flow test done");
    endtask : t_flow

    task automatic t_cmp();
        run(mk(exec_pkg::COMPARE, 5, 5, 0, 0), 1, 16'h0201);
        check(res.flags[1:0] === 2'h2, "cp equal");
        run(mk(exec_pkg::COMPARE_IMMEDIATE, 3, 4, 0, 0), 1, 16'h0201);
        check(res.flags[2:0] === 3'h5, "cpi borrow");
        flags_in = 8'h01;
        run(mk(exec_pkg::COMPARE_WITH_CARRY, 5, 5, 0, 0), 1, 16'h0201);
        check(res.flags[1:0] === 2'h1, "cpc borrow");
        flags_in = 8'h00;
        run(mk(exec_pkg::SHIFT_LEFT_LOGICAL, 8'h81, 0, 0, 0), 1, 16'h0201);
        check(res.reg_wdata === 8'h02 && res.flags[0], "lsl");
        sk(exec_pkg::SHIFT_RIGHT_LOGICAL, 8'h81, 0, 1'b0, 1);
        check(res.reg_we && res.reg_wdata === 8'h40, "lsr");
        check(res.flags[4:0] === 5'h19, "lsr");
        @(negedge clk);
        in_op = mk(exec_pkg::COMPARE, 5, 5, 0, 0);
        in_valid = 1'b1;
        run(mk(exec_pkg::BRANCH_FLAG_SET, 0, 0, 1, 0), 2, 16'h01fd);
        $display("compare test done");
    endtask : t_cmp

    task automatic t_skip();
        sk(exec_pkg::COMPARE_SKIP_EQUAL, 5, 5, 1'b0, 2);
        sk(exec_pkg::COMPARE_SKIP_EQUAL, 5, 5, 1'b1, 3);
        sk(exec_pkg::COMPARE_SKIP_EQUAL, 5, 6, 1'b1, 1);
        sk(exec_pkg::SKIP_REG_BIT_CLEAR, 8'hf7, 8'hf7, 1'b0, 2);
        sk(exec_pkg::SKIP_REG_BIT_SET, 8'h08, 8'h08, 1'b1, 3);
        sk(exec_pkg::SKIP_REG_BIT_SET, 8'hf7, 8'hf7, 1'b0, 1);
        sk(exec_pkg::SKIP_IO_BIT_CLEAR, 8'hf7, 0, 1'b0, 2);
        sk(exec_pkg::SKIP_IO_BIT_CLEAR, 8'h08, 0, 1'b1, 1);
        sk(exec_pkg::SKIP_IO_BIT_SET, 8'h08, 0, 1'b1, 3);
        sk(exec_pkg::NO_OP, 0, 0, 1'b0, 1);
        $display("skip test done");
    endtask : t_skip

    // each branch kind taken, then with its tested bit flipped
    task automatic t_branch();
        logic [7:0] tf[14] = '{8'h40, 8'hbf, 8'hfe, 8'h01, 8'h0c, 8'h04,
            8'h20, 8'hdf, 8'h40, 8'hbf, 8'h08, 8'hf7, 8'h80, 8'h7f};
        logic [7:0] fm[7] = '{8'h40, 8'h01, 8'h08, 8'h20, 8'h40, 8'h08,
            8'h80};
        exec_pkg::op_kind_t k;
        for (int i = 0; i < 14; i++)
        begin
            k = exec_pkg::op_kind_t'(exec_pkg::BRANCH_FLAG_SET + i);
            flags_in = tf[i];
            run(mk(k, 0, 0, 3'h6, 0), 2, 16'h01fd);
            flags_in = tf[i] ^ fm[i / 2];
            run(mk(k, 0, 0, 3'h6, 0), 1, 16'h0201);
        end
        flags_in = 8'h00;
        $display("branch test done");
    endtask : t_branch

    task automatic t_io();
        run(mk(exec_pkg::IO_BIT_SET, 8'h81, 0, 3'h3, 0), 2, 16'h0201);
        check(res.io_we && res.io_wdata === 8'h89, "sbi");
        run(mk(exec_pkg::IO_BIT_CLEAR, 8'hff, 0, 3'h0, 0), 2, 16'h0201);
        check({res.io_addr, res.io_wdata} === 14'h15fe, "cbi");
        $display("io bit test done");
    endtask : t_io

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_flow();
        t_cmp();
        t_skip();
        t_branch();
        t_io();
        summarize();
    end

    // a few hundred cycles suffice; far more means a hang
    initial
    begin
        repeat (3000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule : branch_skip_bit_exec_unit_tb

bind branch_skip_bit_exec_unit branch_skip_bit_exec_unit_chk chk_u (
    .clk(clk), .rst(rst), .in_valid(in_valid), .in_op(in_op),
    .pc_in(pc_in), .z_in(z_in), .stack_in(stack_in), .flags_in(flags_in),
    .in_ready(in_ready), .res(res));

`default_nettype wire
